// File: core/hap_host_access_port.sv
// Host access port sequencer driving local memory cycles
//
// Functional notes
// - A pending host request is sampled at the end of Q4 and its memory cycle starts in the next Q1.
// - A read that misses the prefetch and arrives after the Q4 sampling point waits for the next Q4.
// - On a read, ready rises at Q2 start and the latch strobe rises at Q4 start.
// - In block mode a read of the next location starts when the host ends its read.
// - In block mode each removal of the read strobe or of select starts a further prefetch.
// - A memory read address equal to the prefetched one gets ready at once.
// - In read-modify-write mode a read of the location starts when the host ends its write.
// - An I/O register read suppresses transfer enable and column strobe and drives outbound direction.
// - I/O register accesses work in random, block and read-modify-write modes.
// - A host write gets ready on recognition when no earlier write is still in progress.
// - A write arriving during a pending memory write waits for ready until that write ends.
// - Inbound direction is held active through a host write cycle.
`timescale 1ns/10ps
module hap_host_access_port (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Mode
  input  wire hap_pkg::hap_mode_t       mode,
  // Host side
  input  wire hap_pkg::hap_host_t       host,
  output logic                          host_ready_out,
  output logic                          host_latch_strobe,
  // Local memory side
  output hap_pkg::hap_mem_t             mem,
  output logic [hap_pkg::HAP_ADDR_W-1:0] mem_addr,
  output logic                          quarter_q4
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    hap_pkg::hap_q_t               q;
    hap_pkg::hap_st_t              st;
    logic                          is_write;
    logic                          is_io;
    logic                          is_pref;
    logic                          pref_valid;
    logic [hap_pkg::HAP_ADDR_W-1:0] pref_addr;
    logic [hap_pkg::HAP_ADDR_W-1:0] addr;
    logic                          served;
    logic                          ready;
    logic                          latch;
    logic                          pend_pref;
    logic [hap_pkg::HAP_ADDR_W-1:0] pend_addr;
    logic                          act_q;
    logic                          rd_q;
    hap_pkg::hap_mem_t             mem;
  } hap_state_t;

  hap_state_t s_q;
  hap_state_t s_d;

  logic active;
  logic host_rd;
  logic host_wr;
  logic end_rd;
  logic end_wr;
  logic hit;

  assign active  = !host.select_n && (host.read_strobe || host.write_strobe);
  assign host_rd = !host.select_n && host.read_strobe;
  assign host_wr = !host.select_n && host.write_strobe;
  assign end_rd  = s_q.rd_q && !host_rd;
  assign end_wr  = s_q.act_q && !s_q.rd_q && !active;
  assign hit     = s_q.pref_valid && (host.addr == s_q.pref_addr)
                   && !host.io_space;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.act_q = active;
    s_d.rd_q  = host_rd;
    s_d.latch = 1'b0;
    unique case (s_q.q)
      hap_pkg::HAP_Q1: s_d.q = hap_pkg::HAP_Q2;
      hap_pkg::HAP_Q2: s_d.q = hap_pkg::HAP_Q3;
      hap_pkg::HAP_Q3: s_d.q = hap_pkg::HAP_Q4;
      hap_pkg::HAP_Q4: s_d.q = hap_pkg::HAP_Q1;
    endcase
    if (!active) begin
      s_d.served = 1'b0;
      s_d.ready  = 1'b0;
    end
    // Prefetch launch on end of read or write
    if ((mode == hap_pkg::HAP_MODE_BLOCK && end_rd) ||
        (mode == hap_pkg::HAP_MODE_RMW && end_wr)) begin
      s_d.pend_pref  = 1'b1;
      s_d.pend_addr  = (mode == hap_pkg::HAP_MODE_BLOCK)
                     ? s_q.addr + hap_pkg::HAP_ADDR_W'(hap_pkg::HAP_ADDR_INC)
                     : s_q.addr;
      s_d.pref_valid = 1'b0;
    end
    // Read hit on prefetched data
    if (host_rd && !s_q.served && hit) begin
      s_d.ready  = 1'b1;
      s_d.served = 1'b1;
      s_d.latch  = 1'b1;
    end
    // Write acknowledged when no write is in flight
    if (host_wr && !s_q.served &&
        !(s_q.st != hap_pkg::HAP_IDLE && s_q.is_write)) begin
      s_d.ready  = 1'b1;
      s_d.served = 1'b1;
      s_d.addr   = host.addr;
    end
    unique case (s_q.st)
      hap_pkg::HAP_IDLE: begin
        if (s_q.q == hap_pkg::HAP_Q4) begin
          // Sample at Q4, cycle starts next Q1
          if (active && !s_q.served && !(host_rd && hit)) begin
            s_d.st       = hap_pkg::HAP_RUN;
            s_d.is_write = host_wr;
            s_d.is_io    = host.io_space;
            s_d.is_pref  = 1'b0;
            s_d.addr     = host.addr;
            s_d.pref_valid = 1'b0;
            if (host_wr) begin
              s_d.ready  = 1'b1;
              s_d.served = 1'b1;
            end
          end else if (s_q.pend_pref) begin
            s_d.st        = hap_pkg::HAP_RUN;
            s_d.is_write  = 1'b0;
            s_d.is_io     = 1'b0;
            s_d.is_pref   = 1'b1;
            s_d.addr      = s_q.pend_addr;
            s_d.pend_pref = 1'b0;
          end
        end
      end
      hap_pkg::HAP_RUN: begin
        if (s_q.q == hap_pkg::HAP_Q1) begin
          if (!s_q.is_pref && !s_q.is_write) begin
            s_d.ready  = 1'b1;
            s_d.served = 1'b1;
          end
          s_d.st = hap_pkg::HAP_DONE;
        end
      end
      hap_pkg::HAP_DONE: begin
        if (s_q.q == hap_pkg::HAP_Q3) begin
          // Memory write ends at Q4 start
          s_d.st    = hap_pkg::HAP_IDLE;
          if (!s_q.is_write && !s_q.is_pref) begin
            s_d.latch = 1'b1;
          end
          if (s_q.is_pref) begin
            s_d.pref_valid = 1'b1;
            s_d.pref_addr  = s_q.addr;
          end
        end
      end
      default: s_d.st = hap_pkg::HAP_IDLE;
    endcase
    // Memory strobes
    s_d.mem = '0;
    if (s_d.st == hap_pkg::HAP_DONE) begin
      s_d.mem.addr_latch_strobe = 1'b1;
      s_d.mem.host_latch_output_enable = s_d.is_write;
      s_d.mem.transfer_output_enable = !s_d.is_write && !s_d.is_io;
      s_d.mem.col_strobe_n = s_d.is_io;
      s_d.mem.write_enable_n = !s_d.is_write;
      s_d.mem.dir_outbound_enable = !s_d.is_write && s_d.is_io;
    end else begin
      s_d.mem.col_strobe_n   = 1'b1;
      s_d.mem.write_enable_n = 1'b1;
    end
    s_d.mem.dir_inbound_enable = host_wr ||
      (s_d.st != hap_pkg::HAP_IDLE && s_d.is_write);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign host_ready_out    = s_q.ready;
  assign host_latch_strobe = s_q.latch;
  assign mem               = s_q.mem;
  assign mem_addr          = s_q.addr;
  assign quarter_q4        = (s_q.q == hap_pkg::HAP_Q4);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence seq_read_start;
    s_q.st == hap_pkg::HAP_RUN && !s_q.is_write && !s_q.is_pref
      && s_q.q == hap_pkg::HAP_Q1;
  endsequence

  AST_START_Q1: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s_q.st == hap_pkg::HAP_RUN) |-> s_q.q == hap_pkg::HAP_Q1)
    else $error("Memory cycle not started in Q1");

  AST_NO_LATE: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == hap_pkg::HAP_IDLE && s_q.q != hap_pkg::HAP_Q4) |=>
    s_q.st != hap_pkg::HAP_RUN)
    else $error("Request taken outside Q4");

  AST_READ_TIMING: assert property (@(posedge clk) disable iff (!resetn)
    seq_read_start |=> host_ready_out ##2 host_latch_strobe)
    else $error("Read ready or latch strobe mistimed");

  AST_BLOCK_PREF: assert property (@(posedge clk) disable iff (!resetn)
    (mode == hap_pkg::HAP_MODE_BLOCK && end_rd) |=> s_q.pend_pref)
    else $error("Block prefetch not queued");

  AST_RMW_PREF: assert property (@(posedge clk) disable iff (!resetn)
    (mode == hap_pkg::HAP_MODE_RMW && end_wr) |=>
    s_q.pend_pref && s_q.pend_addr == $past(s_q.addr))
    else $error("Read after write not queued");

  AST_HIT_READY: assert property (@(posedge clk) disable iff (!resetn)
    (host_rd && !s_q.served && hit) |=> host_ready_out && host_latch_strobe)
    else $error("Prefetch hit not answered at once");

  AST_IO_READ: assert property (@(posedge clk) disable iff (!resetn)
    (mem.addr_latch_strobe && s_q.is_io && !s_q.is_write) |->
    !mem.transfer_output_enable && mem.col_strobe_n && mem.dir_outbound_enable)
    else $error("I/O read strobes wrong");

  AST_WR_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (host_wr && !s_q.served && s_q.is_write && s_q.st == hap_pkg::HAP_DONE
     && s_q.q != hap_pkg::HAP_Q3) |=> !host_ready_out)
    else $error("Ready given during pending write");

  AST_DIR_INBOUND_ENABLE: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == hap_pkg::HAP_DONE && s_q.is_write) |->
    mem.dir_inbound_enable)
    else $error("Inbound direction dropped in write");

  // ****************************************************************
  // Further checks
  // ****************************************************************
  sequence seq_block_end;
    mode == hap_pkg::HAP_MODE_BLOCK && end_rd;
  endsequence

  sequence seq_q4_take;
    s_q.st == hap_pkg::HAP_IDLE && s_q.q == hap_pkg::HAP_Q4
      && active && !s_q.served;
  endsequence

  AST_LATCH_ONE: assert property (@(posedge clk) disable iff (!resetn)
    host_latch_strobe |=> !host_latch_strobe)
    else $error("Latch strobe longer than one cycle");

  AST_READY_DROP: assert property (@(posedge clk) disable iff (!resetn)
    !active |=> !host_ready_out)
    else $error("Ready held after host went idle");

  AST_WR_READY: assert property (@(posedge clk) disable iff (!resetn)
    (host_wr && !s_q.served && s_q.st == hap_pkg::HAP_IDLE)
    |=> host_ready_out)
    else $error("Write not acknowledged at once");

  AST_Q_ORDER: assert property (@(posedge clk) disable iff (!resetn)
    s_q.q == hap_pkg::HAP_Q4 |=> s_q.q == hap_pkg::HAP_Q1)
    else $error("Quarter cycle order broken");

  AST_BLOCK_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    seq_block_end |=> s_q.pend_addr == $past(s_q.addr)
      + hap_pkg::HAP_ADDR_W'(hap_pkg::HAP_ADDR_INC))
    else $error("Block prefetch address not sequential");

  AST_IO_TAKE: assert property (@(posedge clk) disable iff (!resetn)
    seq_q4_take ##0 host.io_space |=> s_q.is_io && !s_q.is_pref)
    else $error("I/O access not taken as I/O");

  AST_MISS_DROP: assert property (@(posedge clk) disable iff (!resetn)
    seq_q4_take ##0 (host_rd && !hit) |=> !s_q.pref_valid
      && s_q.st == hap_pkg::HAP_RUN)
    else $error("Prefetch miss did not start a fresh access");

  AST_HIT_NO_CYCLE: assert property (@(posedge clk) disable iff (!resetn)
    seq_q4_take ##0 (host_rd && hit && !s_q.pend_pref)
    |=> s_q.st == hap_pkg::HAP_IDLE)
    else $error("Prefetch hit started a memory cycle");

  AST_WR_START: assert property (@(posedge clk) disable iff (!resetn)
    seq_q4_take ##0 host_wr |=> s_q.is_write && host_ready_out)
    else $error("Write not started at Q4");

endmodule

// File: core/hap_pkg.sv
// Package of types and constants for the host access port
package hap_pkg;

  // ****************************************************************
  // Quarter cycles
  // ****************************************************************
  typedef enum logic [1:0] {
    HAP_Q1 = 2'h0,
    HAP_Q2 = 2'h1,
    HAP_Q3 = 2'h3,
    HAP_Q4 = 2'h2
  } hap_q_t;

  localparam logic [1:0] HAP_Q_RESET = 2'h0;

  // ****************************************************************
  // Host access modes
  // ****************************************************************
  typedef enum logic [1:0] {
    HAP_MODE_RANDOM = 2'h0,
    HAP_MODE_BLOCK  = 2'h1,
    HAP_MODE_RMW    = 2'h2
  } hap_mode_t;

  // ****************************************************************
  // Memory cycle states
  // ****************************************************************
  typedef enum logic [1:0] {
    HAP_IDLE = 2'h0,
    HAP_WAIT = 2'h1,
    HAP_RUN  = 2'h3,
    HAP_DONE = 2'h2
  } hap_st_t;

  localparam int HAP_ADDR_W  = 27;
  localparam int HAP_ADDR_INC = 1;

  // ****************************************************************
  // Host side pins
  // ****************************************************************
  typedef struct packed {
    logic                  select_n;
    logic                  read_strobe;
    logic                  write_strobe;
    logic                  io_space;
    logic [HAP_ADDR_W-1:0] addr;
  } hap_host_t;

  // ****************************************************************
  // Local memory strobes
  // ****************************************************************
  typedef struct packed {
    logic addr_latch_strobe;
    logic transfer_output_enable;
    logic col_strobe_n;
    logic write_enable_n;
    logic host_latch_output_enable;
    logic dir_outbound_enable;
    logic dir_inbound_enable;
  } hap_mem_t;

endpackage

// File: test/hap_host_model.sv
// Host processor model with external data latches
`timescale 1ns/10ps
module hap_host_model (
  // Clock
  input  wire logic              clk,
  // Device answers
  input  wire logic              ready,
  input  wire logic              latch_strobe,
  input  wire logic              q4,
  input  wire hap_pkg::hap_mem_t mem,
  // Host pins
  output hap_pkg::hap_host_t     host
);
  int   lat_rdy;
  int   lat_lst;
  logic one_shot;
  logic track;
  logic saw_toe;
  logic saw_out;
  logic saw_in;

  initial begin
    host          = '0;
    host.select_n = 1'b1;
    track         = 1'b0;
  end

  always @(posedge clk) begin
    if (track) begin
      saw_toe = saw_toe | mem.transfer_output_enable;
      saw_out = saw_out | mem.dir_outbound_enable;
      saw_in  = saw_in | mem.dir_inbound_enable;
    end
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // One access; align puts the request in Q4, else just past Q4
  task automatic access(input logic wr, input logic io,
                        input logic [hap_pkg::HAP_ADDR_W-1:0] a,
                        input logic align);
    int k;
    k = 0;
    do begin
      step();
      k++;
    end while (q4 !== 1'b1 && k < 8);
    if (!align) step();
    {saw_toe, saw_out, saw_in} = 3'h0;
    track = 1'b1;
    host.addr = a;
    host.io_space = io;
    host.read_strobe = !wr;
    host.write_strobe = wr;
    host.select_n = 1'b0;
    lat_rdy = 0;
    while (ready !== 1'b1 && lat_rdy < 40) begin
      step();
      lat_rdy++;
    end
    // Select and strobes drop on ready; address shows the inverse
    host.select_n = 1'b1;
    host.read_strobe = 1'b0;
    host.write_strobe = 1'b0;
    host.addr = ~a;
    lat_lst = 0;
    while (!wr && latch_strobe !== 1'b1 && lat_lst < 8) begin
      step();
      lat_lst++;
    end
    step();
    one_shot = (latch_strobe === 1'b0);
    // No new latch data until the memory write ends in Q4
    while (wr && q4 !== 1'b1 && k < 16) begin
      step();
      k++;
    end
    step();
    track = 1'b0;
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking testbench for the host access port
`timescale 1ns/10ps
module tb_top;
  logic                           clk;
  logic                           resetn;
  hap_pkg::hap_mode_t             mode;
  hap_pkg::hap_host_t             host;
  logic                           host_ready_out;
  logic                           host_latch_strobe;
  hap_pkg::hap_mem_t              mem;
  logic [hap_pkg::HAP_ADDR_W-1:0] mem_addr;
  logic                           quarter_q4;
  int                             miscompares;
  int                             n_checks;
  localparam logic [26:0]         A0 = 27'h000_0040;
  localparam logic [26:0]         A1 = 27'h012_3450;
  localparam logic [26:0]         A2 = 27'h000_0800;
  localparam logic [26:0]         A3 = 27'h3FF_FFF0;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  hap_host_access_port dut (.clk(clk), .resetn(resetn), .mode(mode),
    .host(host), .host_ready_out(host_ready_out),
    .host_latch_strobe(host_latch_strobe), .mem(mem),
    .mem_addr(mem_addr), .quarter_q4(quarter_q4));

  hap_host_model u_host (.clk(clk), .ready(host_ready_out),
    .latch_strobe(host_latch_strobe), .q4(quarter_q4), .mem(mem),
    .host(host));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic acc(input logic wr, input logic io,
                     input logic [26:0] a, input logic align);
    u_host.access(wr, io, a, align);
    if (u_host.lat_rdy >= 40) begin
      miscompares++;
      $display("mismatch ready expected high seen timeout");
      end_of_test();
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_phase();
    int k;
    k = 0;
    while (quarter_q4 !== 1'b1 && k < 8) begin
      u_host.step();
      k++;
    end
    k = 0;
    do begin
      u_host.step();
      k++;
    end while (quarter_q4 !== 1'b1 && k < 8);
    check("q4 period", k, 4);
    check("idle ready", host_ready_out, 0);
    $display("test phase done");
  endtask

  task automatic t_read();
    acc(1'b0, 1'b0, A0, 1'b1);
    check("read ready", u_host.lat_rdy, 2);
    check("mem addr", mem_addr, A0);
    check("latch strobe", u_host.lat_lst, 2);
    check("strobe width", u_host.one_shot, 1);
    acc(1'b0, 1'b0, A1, 1'b0);
    check("late ready", u_host.lat_rdy, 5);
    acc(1'b0, 1'b1, A2, 1'b1);
    check("io toe", u_host.saw_toe, 0);
    check("io out", u_host.saw_out, 1);
    $display("test read done");
  endtask

  task automatic t_write();
    acc(1'b1, 1'b0, A3, 1'b1);
    check("write ready", u_host.lat_rdy, 1);
    check("inbound", u_host.saw_in, 1);
    acc(1'b1, 1'b0, A3 + 27'h1, 1'b1);
    check("second write", u_host.lat_rdy, 1);
    $display("test write done");
  endtask

  task automatic t_prefetch();
    mode = hap_pkg::HAP_MODE_BLOCK;
    acc(1'b0, 1'b0, A1, 1'b1);
    check("block first", u_host.lat_rdy, 2);
    acc(1'b0, 1'b0, A1 + 27'h1, 1'b1);
    check("block hit", u_host.lat_rdy, 1);
    acc(1'b0, 1'b0, A1 + 27'h2, 1'b0);
    check("block again", u_host.lat_rdy, 4);
    acc(1'b0, 1'b0, A0, 1'b1);
    check("block miss", u_host.lat_rdy, 2);
    mode = hap_pkg::HAP_MODE_RMW;
    acc(1'b1, 1'b0, A2, 1'b1);
    acc(1'b0, 1'b0, A2, 1'b1);
    check("rmw hit", u_host.lat_rdy, 1);
    $display("test prefetch done");
  endtask

  task automatic t_io_modes();
    for (int m = 0; m < 3; m++) begin
      mode = hap_pkg::hap_mode_t'(m);
      acc(1'b0, 1'b1, A2, 1'b1);
      check("mode io out", u_host.saw_out, 1);
      check("mode io toe", u_host.saw_toe, 0);
    end
    $display("test io modes done");
  endtask

  initial begin
    miscompares = 0;
    n_checks = 0;
    mode = hap_pkg::HAP_MODE_RANDOM;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_phase();
    t_read();
    t_write();
    t_prefetch();
    t_io_modes();
    end_of_test();
  end
endmodule
